// [design/tri_level_gate_drive_control.sv]
// Top level: tri-level gate drive sequencing, lockout and thermal flag
//
// Contract
// - Gates off unless supply good and enable driven high.
// - Warning trip pulls thermal flag low; switching continues.
// - Flag releases only after temperature drops through warning hysteresis.
// - Shutdown trip forces gates off until below shutdown hysteresis.
// - Open skip-mode input reads as high.
// - Skip-mode mid acts as high and engages pulse-width bias divider.
// - Skip-mode low runs low side straight from pulse-width input.
// - Skip-mode low with pulse-width mid: both gates off at once.
// - Pulse-width high: high side on; low: low side on.
// - Skip high or mid, pulse-width mid: high off, low on.
// - Low side held through debounce and blanking, then zero-current off.
// - Zero-current after the wait turns low side off.
// - Zero-current during the wait ignored; low side off at wait end.
// - Debounce 80 ns then blanking 250 ns before monitoring.
// - Each enable rising edge starts a 25 us calibration cycle.
// - Gate turns on only after opposite off and a delay timer.
`timescale 1ns/1ps
module tri_level_gate_drive_control #(
   parameter int CAL_CYCLES = gate_drive_pkg::CAL_CYC
) (
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic [1:0] pwm_level_i,
   input  wire logic [1:0] skip_mode_n_level_i,
   input  wire logic       driver_enable_n_i,
   input  wire logic       driver_enable_open_i,
   input  wire logic       supply_lockout_ok_i,
   input  wire logic       zero_current_detect_i,
   input  wire logic       warn_temp_trip_i,
   input  wire logic       warn_temp_clear_i,
   input  wire logic       shutdown_temp_trip_i,
   input  wire logic       shutdown_temp_clear_i,
   input  wire logic       high_side_off_sense_i,
   input  wire logic       low_side_off_sense_i,
   output logic            high_side_gate_o,
   output logic            low_side_gate_o,
   output logic            thermal_warn_flag_n_o,
   output logic            thermal_warn_flag_n_oe_o,
   output logic            pwm_bias_en_o,
   output logic            calibrating_o
);
   localparam int NS = 14;
   localparam logic [NS-1:0] SYNC_RST = 14'h0000;

   logic [NS-1:0] raw;
   logic [NS-1:0] syn;

   // All pins arrive from outside the clock domain
   assign raw = {pwm_level_i, skip_mode_n_level_i, driver_enable_n_i,
                 driver_enable_open_i, supply_lockout_ok_i,
                 zero_current_detect_i, warn_temp_trip_i, warn_temp_clear_i,
                 shutdown_temp_trip_i, shutdown_temp_clear_i,
                 high_side_off_sense_i, low_side_off_sense_i};

   pin_sync #(.W(NS)) u_sync (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .pin_i     (raw),
      .rst_val_i (SYNC_RST),
      .level_o   (syn)
   );

   logic [1:0] pwm_lvl;
   logic [1:0] skip_lvl;
   logic       en_pin;
   logic       en_open;
   logic       uv_ok;
   logic       zero_current_detect;
   logic       warn_trip;
   logic       warn_clr;
   logic       sd_trip;
   logic       sd_clr;
   logic       hs_off;
   logic       ls_off;

   assign {pwm_lvl, skip_lvl, en_pin, en_open, uv_ok, zero_current_detect, warn_trip,
           warn_clr, sd_trip, sd_clr, hs_off, ls_off} = syn;

   // Level decode helper, used for both tri-level inputs
   function automatic logic is_lvl(input logic [1:0] v,
                                   input logic [1:0] want);
      is_lvl = (v == want);
   endfunction

   logic skip_low;
   logic pwm_high;
   logic pwm_low;
   logic pwm_mid;
   logic enabled;

   // Open skip input counts as high; only a driven low selects that mode
   assign skip_low = is_lvl(skip_lvl, gate_drive_pkg::LVL_LOW);
   assign pwm_high = is_lvl(pwm_lvl, gate_drive_pkg::LVL_HIGH);
   assign pwm_low  = is_lvl(pwm_lvl, gate_drive_pkg::LVL_LOW);
   assign pwm_mid  = !pwm_high && !pwm_low;

   logic shutdown_r;

   // Open enable counts as low even if the comparator reads high
   assign enabled = uv_ok && en_pin && !en_open && !shutdown_r;

   // Shutdown latch with hysteresis: clear comparator ends it
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         shutdown_r <= 1'b0;
      end else if (sd_trip) begin
         shutdown_r <= 1'b1;
      end else if (sd_clr) begin
         shutdown_r <= 1'b0;
      end
   end

   // Warning flag: trip pulls low, only the hysteresis clear releases
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         thermal_warn_flag_n_oe_o <= 1'b0;
      end else if (warn_trip) begin
         thermal_warn_flag_n_oe_o <= 1'b1;
      end else if (warn_clr) begin
         thermal_warn_flag_n_oe_o <= 1'b0;
      end
   end

   // Open drain only ever drives low
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         thermal_warn_flag_n_o <= 1'b0;
      end else begin
         thermal_warn_flag_n_o <= 1'b0;
      end
   end

   // Bias divider follows the mid skip level
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pwm_bias_en_o <= 1'b0;
      end else begin
         pwm_bias_en_o <= is_lvl(skip_lvl, gate_drive_pkg::LVL_MID);
      end
   end

   // Calibration timer restarted by each enable rising edge
   logic       en_q_r;
   logic [20:0] cal_cnt_r;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         en_q_r    <= 1'b0;
         cal_cnt_r <= 21'h000000;
      end else begin
         en_q_r <= en_pin && !en_open;
         if (en_pin && !en_open && !en_q_r) begin
            cal_cnt_r <= 21'(CAL_CYCLES);
         end else if (cal_cnt_r != 21'h000000) begin
            cal_cnt_r <= cal_cnt_r - 21'h000001;
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         calibrating_o <= 1'b0;
      end else begin
         calibrating_o <= (cal_cnt_r > 21'h000001) ||
                          (en_pin && !en_open && !en_q_r);
      end
   end

   // Zero-current sequence: debounce, blanking, then monitor
   gate_drive_pkg::zc_state_t zc_r;
   logic [gate_drive_pkg::TMR_W-1:0] zc_tmr_r;
   logic zc_done_r;
   logic zc_mode;
   assign zc_mode = enabled && !skip_low && pwm_mid;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         zc_r      <= gate_drive_pkg::ZC_IDLE;
         zc_tmr_r  <= gate_drive_pkg::TMR_ZERO;
         zc_done_r <= 1'b0;
      end else if (!zc_mode) begin
         zc_r      <= gate_drive_pkg::ZC_IDLE;
         zc_tmr_r  <= gate_drive_pkg::TMR_ZERO;
         zc_done_r <= 1'b0;
      end else begin
         case (zc_r)
            gate_drive_pkg::ZC_IDLE: begin
               if (!zc_done_r) begin
                  zc_r     <= gate_drive_pkg::ZC_DEBOUNCE;
                  zc_tmr_r <= 11'(gate_drive_pkg::DEBOUNCE_CYC - 1);
               end
            end
            gate_drive_pkg::ZC_DEBOUNCE: begin
               if (zc_tmr_r == gate_drive_pkg::TMR_ZERO) begin
                  zc_r     <= gate_drive_pkg::ZC_BLANK;
                  zc_tmr_r <= 11'(gate_drive_pkg::BLANK_CYC - 1);
               end else begin
                  zc_tmr_r <= zc_tmr_r - 11'h001;
               end
            end
            gate_drive_pkg::ZC_BLANK: begin
               if (zc_tmr_r == gate_drive_pkg::TMR_ZERO) begin
                  // Detection still present as the wait expires ends it right here
                  if (zero_current_detect) begin
                     zc_r      <= gate_drive_pkg::ZC_IDLE;
                     zc_done_r <= 1'b1;
                  end else begin
                     zc_r <= gate_drive_pkg::ZC_MONITOR;
                  end
               end else begin
                  zc_tmr_r <= zc_tmr_r - 11'h001;
               end
            end
            gate_drive_pkg::ZC_MONITOR: begin
               if (zero_current_detect) begin
                  zc_r      <= gate_drive_pkg::ZC_IDLE;
                  zc_done_r <= 1'b1;
               end
            end
            default: begin
               zc_r <= gate_drive_pkg::ZC_IDLE;
            end
         endcase
      end
   end

   // Requested gate states before non-overlap
   logic hs_req;
   logic ls_req;
   always_comb begin
      hs_req = 1'b0;
      ls_req = 1'b0;
      if (enabled) begin
         if (pwm_high) begin
            hs_req = 1'b1;
         end else if (pwm_low) begin
            ls_req = 1'b1;
         end else if (!skip_low) begin
            ls_req = !zc_done_r;
         end
      end
   end

   // Non-overlap: opposite off sensed and gate command low, then delay
   logic [gate_drive_pkg::TMR_W-1:0] nol_hs_r;
   logic [gate_drive_pkg::TMR_W-1:0] nol_ls_r;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         nol_hs_r <= gate_drive_pkg::TMR_ZERO;
         nol_ls_r <= gate_drive_pkg::TMR_ZERO;
      end else begin
         if (!hs_req || low_side_gate_o || !ls_off) begin
            nol_hs_r <= gate_drive_pkg::TMR_ZERO;
         end else if (nol_hs_r != 11'(gate_drive_pkg::NOL_CYC)) begin
            nol_hs_r <= nol_hs_r + 11'h001;
         end
         if (!ls_req || high_side_gate_o || !hs_off) begin
            nol_ls_r <= gate_drive_pkg::TMR_ZERO;
         end else if (nol_ls_r != 11'(gate_drive_pkg::NOL_CYC)) begin
            nol_ls_r <= nol_ls_r + 11'h001;
         end
      end
   end

   // Turn-off is immediate, turn-on waits for non-overlap expiry
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         high_side_gate_o <= 1'b0;
         low_side_gate_o  <= 1'b0;
      end else begin
         // Mid with skip low drops both in the same edge
         high_side_gate_o <= hs_req &&
            (high_side_gate_o || nol_hs_r == 11'(gate_drive_pkg::NOL_CYC));
         low_side_gate_o  <= ls_req &&
            (low_side_gate_o || nol_ls_r == 11'(gate_drive_pkg::NOL_CYC));
      end
   end
endmodule

// [design/gate_drive_pkg.sv]
// Shared constants for the tri-level gate drive control block
package gate_drive_pkg;

   // Two-bit level codes from the window comparators
   localparam logic [1:0] LVL_LOW  = 2'h0;
   localparam logic [1:0] LVL_MID  = 2'h1;
   localparam logic [1:0] LVL_HIGH = 2'h2;
   localparam logic [1:0] LVL_OPEN = 2'h3;

   // Clock rate and timing figures
   localparam int CLK_PERIOD_PS   = 20000;
   localparam int DEBOUNCE_NS     = 80;
   localparam int BLANK_NS        = 250;
   localparam int CAL_US          = 25;
   localparam int NOL_NS          = 20;

   // Least times round up to whole cycles
   localparam int DEBOUNCE_CYC =
      (DEBOUNCE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int BLANK_CYC =
      (BLANK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CAL_CYC =
      (CAL_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int NOL_CYC =
      (NOL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   localparam int TMR_W = 11;
   localparam logic [TMR_W-1:0] TMR_ZERO = 11'h000;

   // Zero-current sequence states
   typedef enum logic [1:0] {
      ZC_IDLE,
      ZC_DEBOUNCE,
      ZC_BLANK,
      ZC_MONITOR
   } zc_state_t;

endpackage

// [design/pin_sync.sv]
// Three-stage pin synchroniser with second/third stage agreement filter
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         reset_n_i,
   input  wire logic [W-1:0] pin_i,
   input  wire logic [W-1:0] rst_val_i,
   output logic      [W-1:0] level_o
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] lvl_r;

   // Chain; the first stage feeds only the second
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Accept a change once stages two and three agree, bit by bit
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lvl_r <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               lvl_r[i] <= s3_r[i];
            end
         end
      end
   end

   // Reset value shown until the filter has a level
   logic primed_r;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         primed_r <= 1'b0;
      end else begin
         primed_r <= 1'b1;
      end
   end

   assign level_o = primed_r ? lvl_r : rst_val_i;
endmodule

// [sim/gate_drive_checker.sv]
// Concurrent checks on the gate drive control top-level ports
`timescale 1ns/1ps
module gate_drive_checker #(
   parameter int CAL_CYCLES = 10
) (
   input wire logic       clk_i,
   input wire logic       reset_n_i,
   input wire logic [1:0] pwm_level_i,
   input wire logic [1:0] skip_mode_n_level_i,
   input wire logic       driver_enable_open_i,
   input wire logic       supply_lockout_ok_i,
   input wire logic       warn_temp_trip_i,
   input wire logic       warn_temp_clear_i,
   input wire logic       shutdown_temp_trip_i,
   input wire logic       high_side_gate_o,
   input wire logic       low_side_gate_o,
   input wire logic       thermal_warn_flag_n_oe_o,
   input wire logic       pwm_bias_en_o,
   input wire logic       calibrating_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   logic [3:0]  since_clear_r;
   logic [11:0] cal_len_r;
   logic        pmid;
   logic        shigh;
   logic        off;
   // Code 3 on the pulse-width pin reads as mid, on skip as high
   assign pmid = pwm_level_i inside {gate_drive_pkg::LVL_MID,
                                     gate_drive_pkg::LVL_OPEN};
   assign shigh = skip_mode_n_level_i inside {gate_drive_pkg::LVL_HIGH,
                                              gate_drive_pkg::LVL_OPEN};
   assign off = !high_side_gate_o && !low_side_gate_o;
   // Saturating age of the last clear and wrapping length of the calibration window
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         since_clear_r <= 4'hF;
         cal_len_r     <= 12'h000;
      end else begin
         since_clear_r <= warn_temp_clear_i ? 4'h0 :
                          since_clear_r + {3'h0, since_clear_r != 4'hF};
         cal_len_r     <= calibrating_o ? cal_len_r + 12'h001 : 12'h000;
      end
   end
   // Mid entry with skip high, powered and enabled
   sequence mid_entry;
      $rose(low_side_gate_o) && pmid && shigh && supply_lockout_ok_i &&
      !driver_enable_open_i && !shutdown_temp_trip_i;
   endsequence
   AST_SUPPLY_OFF: assert property ((!supply_lockout_ok_i)[*8] |-> off)
      else $error("gates on without supply");
   AST_OPEN_OFF: assert property (driver_enable_open_i[*8] |-> off)
      else $error("gates on with enable pin open");
   AST_NO_OVERLAP: assert property (!(high_side_gate_o && low_side_gate_o))
      else $error("both gates on");
   AST_HS_AFTER_LS: assert property ($rose(high_side_gate_o) |->
      !$past(low_side_gate_o)) else $error("high side on too early");
   AST_WARN_SET: assert property (warn_temp_trip_i[*8] |->
      thermal_warn_flag_n_oe_o) else $error("warning not flagged");
   AST_WARN_HYST: assert property ($fell(thermal_warn_flag_n_oe_o) |->
      since_clear_r < 4'hA) else $error("flag released without clear");
   AST_SHDN_OFF: assert property (shutdown_temp_trip_i[*8] |-> off)
      else $error("gates on in shutdown");
   AST_BIAS: assert property ((skip_mode_n_level_i ==
      gate_drive_pkg::LVL_MID)[*8] |-> pwm_bias_en_o)
      else $error("bias divider not engaged");
   AST_SKIP_LOW_MID: assert property (((skip_mode_n_level_i ==
      gate_drive_pkg::LVL_LOW) && pmid)[*8] |-> off)
      else $error("gates on at skip low and mid");
   AST_PWM_HIGH: assert property ((pwm_level_i ==
      gate_drive_pkg::LVL_HIGH)[*8] |-> !low_side_gate_o)
      else $error("low side on at pulse high");
   AST_PWM_LOW: assert property ((pwm_level_i ==
      gate_drive_pkg::LVL_LOW)[*8] |-> !high_side_gate_o)
      else $error("high side on at pulse low");
   AST_ZCD_WAIT: assert property (mid_entry |-> low_side_gate_o[*8])
      else $error("low side dropped inside wait");
   AST_CAL_LEN: assert property (calibrating_o |->
      cal_len_r <= 12'(CAL_CYCLES + 1)) else $error("calibration too long");
endmodule

// [sim/buck_controller_model.sv]
// Behavioural multiphase buck controller driving pulse-width and skip pins
`timescale 1ns/1ps
module buck_controller_model (
   input  wire logic       has_zcd_i,
   input  wire logic       float_skip_i,
   input  wire logic       bias_skip_i,
   input  wire logic [1:0] phase_i,
   output logic      [1:0] pwm_level_o,
   output logic      [1:0] skip_mode_n_level_o
);
   // Own zero-current sense means skip low; otherwise high, open or mid
   always_comb begin
      if (has_zcd_i) begin
         skip_mode_n_level_o = gate_drive_pkg::LVL_LOW;
      end else if (bias_skip_i) begin
         skip_mode_n_level_o = gate_drive_pkg::LVL_MID;
      end else if (float_skip_i) begin
         skip_mode_n_level_o = gate_drive_pkg::LVL_OPEN;
      end else begin
         skip_mode_n_level_o = gate_drive_pkg::LVL_HIGH;
      end
   end
   // Phase 2 requests DCM or zero current; phase 3 leaves the pin undriven
   always_comb begin
      case (phase_i)
         2'h0: pwm_level_o = gate_drive_pkg::LVL_LOW;
         2'h1: pwm_level_o = gate_drive_pkg::LVL_HIGH;
         2'h2: pwm_level_o = gate_drive_pkg::LVL_MID;
         default: pwm_level_o = gate_drive_pkg::LVL_OPEN;
      endcase
   end
endmodule

// [sim/testbench.sv]
// Self-checking bench for the tri-level gate drive control block
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
   $display("Error t=%0t got %h exp %h", $time, a, e); end end
module testbench;
   logic clk, rst_n, has_zcd, flt, bsk, en, en_open, sup, zero_current_detect;
   logic wt_trip, wt_clr, sd_trip, sd_clr, hs_off, ls_off;
   logic hs, ls, fl, oe, bias, cal;
   logic [1:0] phase, pwm_lvl, skip_lvl;
   logic [4:0] q[$];
   logic [4:0] exp_v;
   event smp;
   int mismatches, checks_done, cycles;
   int unsigned r;
   buck_controller_model i_buck_controller_model (.has_zcd_i(has_zcd),
      .float_skip_i(flt), .bias_skip_i(bsk), .phase_i(phase),
      .pwm_level_o(pwm_lvl), .skip_mode_n_level_o(skip_lvl));
   tri_level_gate_drive_control #(.CAL_CYCLES(10))
      i_tri_level_gate_drive_control (.clk_i(clk), .reset_n_i(rst_n),
      .pwm_level_i(pwm_lvl), .skip_mode_n_level_i(skip_lvl),
      .driver_enable_n_i(en), .driver_enable_open_i(en_open),
      .supply_lockout_ok_i(sup), .zero_current_detect_i(zero_current_detect),
      .warn_temp_trip_i(wt_trip), .warn_temp_clear_i(wt_clr),
      .shutdown_temp_trip_i(sd_trip), .shutdown_temp_clear_i(sd_clr),
      .high_side_off_sense_i(hs_off), .low_side_off_sense_i(ls_off),
      .high_side_gate_o(hs), .low_side_gate_o(ls),
      .thermal_warn_flag_n_o(fl), .thermal_warn_flag_n_oe_o(oe),
      .pwm_bias_en_o(bias), .calibrating_o(cal));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Power stage: each switch reads off one cycle after its gate drops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {hs_off, ls_off} <= 2'h3;
      end else begin
         {hs_off, ls_off} <= {!hs, !ls};
      end
   end
   // Oldest note against {hs, ls, flag pull, bias, calibrating}
   // Popped once into a variable: the macro names its expected value twice
   always @(smp) begin
      exp_v = q.pop_front();
      `CHK({hs, ls, oe, bias, cal}, exp_v)
      `CHK(fl, 1'b0)
   end
   // Hang guard, far above the roughly 760 cycles of the sequence
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   task automatic wt(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic note(logic [4:0] e);
      q.push_back(e);
      ->smp;
   endtask
   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      r = $urandom(17);
      {rst_n, flt, bsk, en, en_open, sup, zero_current_detect} = 7'h00;
      {wt_trip, wt_clr, sd_trip, sd_clr} = 4'h0;
      has_zcd = 1'b1;
      phase = 2'h2;
      wt(15); note(5'h00);
      wt(1); rst_n = 1'b1; sup = 1'b1; en = 1'b1;
      wt(8); note(5'h01);
      wt(20); note(5'h00);
      // Skip low, high, open and mid against both pulse levels
      for (int m = 0; m < 4; m++) begin
         has_zcd = (m == 0); flt = (m == 2); bsk = (m == 3);
         phase = 2'h1; wt(20); note({3'h4, bsk, 1'b0});
         phase = 2'h0; wt(20); note({3'h2, bsk, 1'b0});
      end
      bsk = 1'b0;
      for (int k = 0; k < 3; k++) begin
         sup = (k != 0); en = (k != 1); en_open = (k == 2);
         wt(20); note(5'h00);
      end
      en_open = 1'b0; wt(20);
      // Mid entry then late and early zero-current events
      phase = 2'h2; wt(20); note(5'h08);
      zero_current_detect = 1'b1; wt(10); note(5'h00);
      zero_current_detect = 1'b0; phase = 2'h1; wt(20); zero_current_detect = 1'b1; phase = 2'h2;
      wt(12); note(5'h08);
      wt(28); note(5'h00);
      zero_current_detect = 1'b0; phase = 2'h1; wt(20);
      wt_trip = 1'b1; wt(20); note(5'h14);
      wt_trip = 1'b0; wt(20); note(5'h14);
      wt_clr = 1'b1; wt(20); note(5'h10); wt_clr = 1'b0;
      sd_trip = 1'b1; wt(20); note(5'h00);
      sd_trip = 1'b0; wt(20); note(5'h00);
      sd_clr = 1'b1; wt(20); note(5'h10); sd_clr = 1'b0;
      has_zcd = 1'b1;
      repeat (12) begin
         phase = 2'($urandom % 4); wt(20);
         note(phase == 2'h0 ? 5'h08 : phase == 2'h1 ? 5'h10 : 5'h00);
      end
      rst_n = 1'b0; wt(2); note(5'h00);
      rst_n = 1'b1; wt(2);
      tally_and_finish();
   end
endmodule
bind tri_level_gate_drive_control gate_drive_checker #(
   .CAL_CYCLES(CAL_CYCLES)) i_gate_drive_checker (.clk_i(clk_i),
   .reset_n_i(reset_n_i), .pwm_level_i(pwm_level_i),
   .skip_mode_n_level_i(skip_mode_n_level_i),
   .driver_enable_open_i(driver_enable_open_i),
   .supply_lockout_ok_i(supply_lockout_ok_i),
   .warn_temp_trip_i(warn_temp_trip_i), .warn_temp_clear_i(warn_temp_clear_i),
   .shutdown_temp_trip_i(shutdown_temp_trip_i),
   .high_side_gate_o(high_side_gate_o), .low_side_gate_o(low_side_gate_o),
   .thermal_warn_flag_n_oe_o(thermal_warn_flag_n_oe_o),
   .pwm_bias_en_o(pwm_bias_en_o), .calibrating_o(calibrating_o));
